// ### host_mcu_model.sv
// host side model: measures the clock handed to the host
`timescale 1ns/1ns
module host_mcu_model (
    input wire logic clk_i, // main clock
    input wire logic host_clock_i, // clock from the block
    output logic [7:0] period_o = 8'h0, // cycles between rises
    output logic [7:0] high_o = 8'h0, // cycles high per pulse
    output logic [15:0] rises_o = 16'h0 // rises seen
);
    logic prev = 1'b0;
    logic [7:0] cnt = 8'h0;
    logic [7:0] hcnt = 8'h0;
    always @(posedge clk_i) begin
        prev <= host_clock_i;
        if (host_clock_i && !prev) begin
            period_o <= cnt;
            cnt <= 8'h1;
            rises_o <= rises_o + 16'h1;
        end else begin
            cnt <= cnt + 8'h1;
        end
        if (host_clock_i) begin
            hcnt <= hcnt + 8'h1;
        end else if (prev) begin
            high_o <= hcnt;
            hcnt <= 8'h0;
        end
    end
endmodule : host_mcu_model

// ### supply_clock_checker.sv
// port assertions for the supply/clock control block
`timescale 1ns/1ns
module supply_clock_checker (
    input wire logic clk_i, // clock
    input wire logic nrst_i, // reset
    input wire supply_clock_pkg::supply_status_t status_i, // status
    input wire logic osc_source_select_i, // pin
    input wire logic bus_load_strap_low_i, // pin
    input wire supply_clock_pkg::tx_events_t tx_i, // events
    input wire logic fixed_buck_run_o, // out
    input wire logic adj_buck_run_o, // out
    input wire logic linear_reg_run_o, // out
    input wire logic [2:0] linear_reg_current_limit_o, // out
    input wire logic xtal_select_o, // out
    input wire logic high_slope_limit_o, // out
    input wire logic tx_schedule_flag_out_o, // out
    input wire logic tx_go_o // out
);
    import supply_clock_pkg::*;
    logic [15:0] lead;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    // cycles the trigger has been up
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lead <= 16'h0;
        end else begin
            lead <= tx_schedule_flag_out_o ? lead + 16'h1 : 16'h0;
        end
    end
    property p_adj_gate;
        !status_i.filtered_supply_ok [*4] |=> !adj_buck_run_o;
    endproperty
    a_adj_gate: assert property (p_adj_gate) else $error("adj buck on");
    property p_lin_gate;
        !status_i.filtered_supply_ok [*4] |=> !linear_reg_run_o;
    endproperty
    a_lin_gate: assert property (p_lin_gate) else $error("regulator on");
    property p_fixed_up;
        $rose(nrst_i) |-> ##[1:5] fixed_buck_run_o;
    endproperty
    a_fixed_up: assert property (p_fixed_up) else $error("fixed buck late");
    property p_fixed_hold;
        fixed_buck_run_o |=> fixed_buck_run_o;
    endproperty
    a_fixed_hold: assert property (p_fixed_hold) else $error("fixed buck off");
    property p_limit_rst;
        $rose(nrst_i) |-> linear_reg_current_limit_o == 3'h4;
    endproperty
    a_limit_rst: assert property (p_limit_rst) else $error("limit reset");
    property p_tx_schedule_flag_out_drop;
        tx_schedule_flag_out_o && (tx_i.tx_done || tx_i.collision) |=> !tx_schedule_flag_out_o;
    endproperty
    a_tx_schedule_flag_out_drop: assert property (p_tx_schedule_flag_out_drop) else $error("trigger held");
    property p_imm_go;
        $rose(tx_schedule_flag_out_o) && $past(tx_i.tx_immediate) |-> tx_go_o;
    endproperty
    a_imm_go: assert property (p_imm_go) else $error("no prompt start");
    property p_lead;
        tx_go_o && lead != 16'h0 |-> lead inside {[16'd12997:16'd13002]};
    endproperty
    a_lead: assert property (p_lead) else $error("lead time");
    property p_slope;
        $stable(bus_load_strap_low_i) [*7] |=> high_slope_limit_o == $past(bus_load_strap_low_i);
    endproperty
    a_slope: assert property (p_slope) else $error("slope select");
    property p_xtal;
        $stable(osc_source_select_i) [*7] |=> xtal_select_o == !$past(osc_source_select_i);
    endproperty
    a_xtal: assert property (p_xtal) else $error("osc select");
    c_lead: cover property (tx_go_o && lead != 16'h0);
    c_drop: cover property ($fell(tx_schedule_flag_out_o));
    c_gate: cover property ($fell(adj_buck_run_o));
endmodule : supply_clock_checker
bind supply_clock_trigger_ctrl supply_clock_checker u_chk (.clk_i, .nrst_i, .status_i, .osc_source_select_i,
    .bus_load_strap_low_i, .tx_i, .fixed_buck_run_o, .adj_buck_run_o, .linear_reg_run_o,
    .linear_reg_current_limit_o, .xtal_select_o, .high_slope_limit_o, .tx_schedule_flag_out_o, .tx_go_o);

// ### supply_clock_pkg.sv
// types shared by the supply/clock control block
package supply_clock_pkg;
    typedef enum logic [1:0] {
        CLK_SRC_INT4,
        CLK_SRC_DIV8,
        CLK_SRC_MAIN16
    } clk_src_t;

    typedef struct packed {
        logic filtered_supply_ok;
        logic adj_rail_status;
        logic twenty_volt_reg_status;
        logic normal_state;
        logic osc_fault;
    } supply_status_t;

    typedef struct packed {
        logic tx_scheduled;
        logic tx_immediate;
        logic tx_start;
        logic tx_done;
        logic collision;
    } tx_events_t;
endpackage : supply_clock_pkg

// ### supply_clock_regs.svh
// register offsets, field positions and timing constants for the supply/clock control block
`ifndef SUPPLY_CLOCK_REGS_SVH
`define SUPPLY_CLOCK_REGS_SVH

`define CTRL_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define LIMIT_OFFSET 4'h8

`define CTRL_ADJ_EN_BIT 0
`define CTRL_LIN_EN_BIT 1
`define CTRL_CLK_EN_BIT 2
`define CTRL_TX_SCHEDULE_FLAG_OUT_EN_BIT 3
`define CTRL_RESET 4'he

`define LIMIT_RESET 3'h4

`define BIT_TIME_NS 104000
`define CLK_PERIOD_NS 8
`define BIT_CYCLES (`BIT_TIME_NS / `CLK_PERIOD_NS)

`define DIV4_LAST 3'h7
`define DIV8_LAST 1'h1

`endif

// ### supply_clock_trigger_ctrl.sv
// supply enable gating, host clock output and transmit trigger with AXI4-Lite registers
//
// How it works
// - fixed buck comes on by itself once reset releases, no host command.
// - clearing the adjustable buck enable bit turns that converter off.
// - adjustable buck runs only while filtered supply flag is set.
// - adjustable rail status readable in the status register.
// - linear regulator enable bit resets to one; clearing it stops regulator.
// - linear regulator runs only while filtered supply flag is set.
// - twenty volt regulator status readable in the status register.
// - current limit field is three bits, resets to 100 binary.
// - oscillator source select pin chooses crystal or external generator.
// - clearing clock output enable bit stops the host clock output.
// - in stand-by after power-up host clock is internal 4 MHz.
// - entering normal state gives 8 MHz strap low, 16 MHz strap high.
// - leaving normal without oscillator fault keeps the 8/16 MHz clock.
// - leaving normal on oscillator fault falls back to 4 MHz.
// - strap not hard low: slope 0.5 mA/ms, start-up current 30 mA.
// - strap hard low: slope 1 mA/ms, start-up current 60 mA.
// - control bit 3 raises trigger one bit ahead; drops on completion or collision.
// - unscheduled frames and responses start right after trigger rises.
// - one bit period, also the trigger lead, is 104 us.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "supply_clock_regs.svh"

module supply_clock_trigger_ctrl (
    input wire logic clk_i, // 32 MHz-class main clock (125 MHz sim rate)
    input wire logic nrst_i, // async active-low reset
    input wire supply_clock_pkg::supply_status_t status_i, // analog status, async
    input wire logic osc_source_select_i, // crystal (0) or external (1), pin
    input wire logic host_clock_rate_strap_i, // low 8 MHz, high 16 MHz, pin
    input wire logic bus_load_strap_low_i, // strap firmly to ground, pin
    input wire supply_clock_pkg::tx_events_t tx_i, // transmit events, same clock
    input wire logic [3:0] awaddr_i, // axi write address
    input wire logic awvalid_i, // axi
    output logic awready_o, // axi
    input wire logic [31:0] wdata_i, // axi
    input wire logic [3:0] wstrb_i, // axi
    input wire logic wvalid_i, // axi
    output logic wready_o, // axi
    output logic [1:0] bresp_o, // axi
    output logic bvalid_o, // axi
    input wire logic bready_i, // axi
    input wire logic [3:0] araddr_i, // axi read address
    input wire logic arvalid_i, // axi
    output logic arready_o, // axi
    output logic [31:0] rdata_o, // axi
    output logic [1:0] rresp_o, // axi
    output logic rvalid_o, // axi
    input wire logic rready_i, // axi
    output logic fixed_buck_run_o, // fixed buck enable
    output logic adj_buck_run_o, // adjustable buck enable
    output logic linear_reg_run_o, // 20 V regulator enable
    output logic [2:0] linear_reg_current_limit_o, // regulator limit code
    output logic xtal_select_o, // oscillator uses crystal
    output logic high_slope_limit_o, // 1 mA/ms, 60 mA start-up
    output logic host_clock_out_o, // clock to host
    output logic tx_schedule_flag_out_o, // debug trigger pin
    output logic tx_go_o // transmitter may start
);
    import supply_clock_pkg::*;

    // bit time in main clock cycles
    localparam int BIT_CYC = `BIT_CYCLES;

    // two-stage release so every flop leaves reset on one edge
    logic rst_meta;
    logic rst_sync;
    logic rstn;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    assign rstn = rst_sync;

    // pin synchronisers
    // status and straps are asynchronous levels: nothing reads the first flop
    supply_status_t st_meta;
    supply_status_t st;
    logic [2:0] pin_meta;
    logic [2:0] pin_s;
    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            st_meta <= '0;
            st <= '0;
            pin_meta <= 3'h0;
            pin_s <= 3'h0;
        end else begin
            st_meta <= status_i;
            st <= st_meta;
            pin_meta <= {osc_source_select_i, host_clock_rate_strap_i, bus_load_strap_low_i};
            pin_s <= pin_meta;
        end
    end

    wire osc_external = pin_s[2];
    wire rate_strap_high = pin_s[1];
    wire strap_grounded = pin_s[0];

    // registers
    logic [3:0] ctrl;
    logic [2:0] limit;

    // axi write path
    // a beat is latched until its partner arrives, so either order works
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = awvalid_i && awready_o;
    wire w_take = wvalid_i && wready_o;
    wire have_aw = aw_held || aw_take;
    wire have_w = w_held || w_take;
    wire [3:0] cur_waddr = aw_held ? aw_addr : awaddr_i;
    wire [31:0] cur_wdata = w_held ? w_data : wdata_i;
    wire [3:0] cur_wstrb = w_held ? w_strb : wstrb_i;
    wire do_write = have_aw && have_w && !bvalid_o;
    // only byte lane 0 carries register bits
    wire wr_ctrl = do_write && cur_waddr == `CTRL_OFFSET && cur_wstrb[0];
    wire wr_limit = do_write && cur_waddr == `LIMIT_OFFSET && cur_wstrb[0];
    wire wr_ok = cur_waddr == `CTRL_OFFSET || cur_waddr == `STATUS_OFFSET || cur_waddr == `LIMIT_OFFSET;
    wire next_awready = !have_aw && !bvalid_o && !awready_o;
    wire next_wready = !have_w && !bvalid_o && !wready_o;
    wire [1:0] next_bresp = wr_ok ? 2'h0 : 2'h2;

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            awready_o <= 1'b0;
            wready_o <= 1'b0;
            bvalid_o <= 1'b0;
            bresp_o <= 2'h0;
        end else begin
            if (aw_take) begin
                aw_addr <= awaddr_i;
            end
            if (w_take) begin
                w_data <= wdata_i;
                w_strb <= wstrb_i;
            end
            aw_held <= have_aw && !do_write;
            w_held <= have_w && !do_write;
            awready_o <= next_awready;
            wready_o <= next_wready;
            if (do_write) begin
                bvalid_o <= 1'b1;
                bresp_o <= next_bresp;
            end else if (bready_i) begin
                bvalid_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `CTRL_RESET;
            limit <= `LIMIT_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= cur_wdata[3:0];
            end
            if (wr_limit) begin
                limit <= cur_wdata[2:0];
            end
        end
    end

    // axi read path
    wire [4:0] status_bits = {st.osc_fault, st.normal_state, st.twenty_volt_reg_status,
                              st.adj_rail_status, st.filtered_supply_ok};
    wire [31:0] status_word = {27'h0, status_bits};
    wire [31:0] ctrl_word = {28'h0, ctrl};
    wire [31:0] limit_word = {29'h0, limit};
    wire rd_ctrl = araddr_i == `CTRL_OFFSET;
    wire rd_stat = araddr_i == `STATUS_OFFSET;
    wire rd_lim = araddr_i == `LIMIT_OFFSET;
    wire rd_ok = rd_ctrl || rd_stat || rd_lim;
    wire [31:0] rd_word = rd_ctrl ? ctrl_word :
                          rd_stat ? status_word :
                          rd_lim ? limit_word : 32'h0;
    wire ar_take = arvalid_i && arready_o;
    wire next_arready = !rvalid_o && !arready_o && !ar_take;

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            arready_o <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0;
            rresp_o <= 2'h0;
        end else begin
            arready_o <= next_arready;
            if (ar_take) begin
                rvalid_o <= 1'b1;
                rdata_o <= rd_word;
                rresp_o <= rd_ok ? 2'h0 : 2'h2;
            end else if (rready_i) begin
                rvalid_o <= 1'b0;
            end
        end
    end

    // run = enable and filtered supply
    wire next_adj_run = ctrl[`CTRL_ADJ_EN_BIT] && st.filtered_supply_ok;
    wire next_lin_run = ctrl[`CTRL_LIN_EN_BIT] && st.filtered_supply_ok;

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            fixed_buck_run_o <= 1'b0;
            adj_buck_run_o <= 1'b0;
            linear_reg_run_o <= 1'b0;
            linear_reg_current_limit_o <= `LIMIT_RESET;
            xtal_select_o <= 1'b0;
            high_slope_limit_o <= 1'b0;
        end else begin
            fixed_buck_run_o <= 1'b1;
            adj_buck_run_o <= next_adj_run;
            linear_reg_run_o <= next_lin_run;
            linear_reg_current_limit_o <= limit;
            xtal_select_o <= !osc_external;
            high_slope_limit_o <= strap_grounded;
        end
    end

    // host clock source selection
    clk_src_t src;
    logic was_normal;
    wire enter_normal = st.normal_state && !was_normal;
    wire leave_on_fault = !st.normal_state && was_normal && st.osc_fault;
    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            src <= CLK_SRC_INT4;
            was_normal <= 1'b0;
        end else begin
            was_normal <= st.normal_state;
            if (enter_normal) begin
                src <= rate_strap_high ? CLK_SRC_MAIN16 : CLK_SRC_DIV8;
            end else if (leave_on_fault) begin
                src <= CLK_SRC_INT4;
            end
        end
    end

    // free-running divider: int4 divides by 8, div8 by 4, main16 by 2
    logic [2:0] div;
    logic next_clk;
    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            div <= 3'h0;
        end else begin
            div <= div + 3'h1;
        end
    end

    always_comb begin
        case (src)
            CLK_SRC_INT4: next_clk = div == `DIV4_LAST;
            CLK_SRC_DIV8: next_clk = div[1] == `DIV8_LAST;
            CLK_SRC_MAIN16: next_clk = !host_clock_out_o;
            default: next_clk = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            host_clock_out_o <= 1'b0;
        end else begin
            // gated at the flop so the pin never glitches
            // enable bit gates output
            host_clock_out_o <= ctrl[`CTRL_CLK_EN_BIT] && next_clk;
        end
    end

    // transmit trigger
    typedef enum logic [1:0] {
        TX_SCHEDULE_FLAG_OUT_IDLE,
        TX_SCHEDULE_FLAG_OUT_LEAD,
        TX_SCHEDULE_FLAG_OUT_SEND
    } tx_schedule_flag_out_state_t;
    tx_schedule_flag_out_state_t tstate;
    tx_schedule_flag_out_state_t next_tstate;
    logic [13:0] lead_cnt;
    logic [13:0] next_lead_cnt;
    logic next_flag;
    logic next_go;
    wire tx_schedule_flag_out_en = ctrl[`CTRL_TX_SCHEDULE_FLAG_OUT_EN_BIT];
    wire tx_schedule_flag_out_end = tx_i.tx_done || tx_i.collision;
    wire lead_over = lead_cnt == 14'h0;

    // requests arriving while busy are ignored
    always_comb begin
        next_tstate = tstate;
        next_lead_cnt = lead_cnt;
        next_flag = tx_schedule_flag_out_o;
        next_go = 1'b0;
        case (tstate)
            TX_SCHEDULE_FLAG_OUT_IDLE: begin
                if (tx_i.tx_immediate) begin
                    next_tstate = TX_SCHEDULE_FLAG_OUT_SEND;
                    next_go = 1'b1;
                    next_flag = tx_schedule_flag_out_en;
                end else if (tx_i.tx_scheduled) begin
                    next_tstate = TX_SCHEDULE_FLAG_OUT_LEAD;
                    next_lead_cnt = 14'(BIT_CYC - 1);
                    next_flag = tx_schedule_flag_out_en;
                end
            end
            // reload to go pulse spans exactly one bit time: BIT_CYC - 1 counts down to zero, plus the zero cycle
            TX_SCHEDULE_FLAG_OUT_LEAD: begin
                if (tx_schedule_flag_out_end) begin
                    next_tstate = TX_SCHEDULE_FLAG_OUT_IDLE;
                    next_flag = 1'b0;
                end else if (lead_over) begin
                    next_tstate = TX_SCHEDULE_FLAG_OUT_SEND;
                    next_go = 1'b1;
                end else begin
                    next_lead_cnt = lead_cnt - 14'h1;
                end
            end
            TX_SCHEDULE_FLAG_OUT_SEND: begin
                if (tx_schedule_flag_out_end) begin
                    next_tstate = TX_SCHEDULE_FLAG_OUT_IDLE;
                    next_flag = 1'b0;
                end
            end
            default: begin
                next_tstate = TX_SCHEDULE_FLAG_OUT_IDLE;
                next_flag = 1'b0;
            end
        endcase
    end

    // tx_go is a one-cycle pulse, the flag a level
    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            tstate <= TX_SCHEDULE_FLAG_OUT_IDLE;
            lead_cnt <= 14'h0;
            tx_schedule_flag_out_o <= 1'b0;
            tx_go_o <= 1'b0;
        end else begin
            tstate <= next_tstate;
            lead_cnt <= next_lead_cnt;
            tx_schedule_flag_out_o <= next_flag;
            tx_go_o <= next_go;
        end
    end
endmodule : supply_clock_trigger_ctrl

// ### supply_clock_trigger_ctrl_tb.sv
// self-checking bench for the supply/clock control block
`timescale 1ns/1ns
module supply_clock_trigger_ctrl_tb;
    import supply_clock_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i, osc_source_select_i, host_clock_rate_strap_i, bus_load_strap_low_i;
    supply_status_t status_i;
    tx_events_t tx_i;
    logic [3:0] awaddr_i, araddr_i, wstrb_i;
    logic [31:0] wdata_i, rdata_o;
    logic awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
    logic [1:0] bresp_o, rresp_o;
    logic fixed_buck_run_o, adj_buck_run_o, linear_reg_run_o, xtal_select_o, high_slope_limit_o;
    logic host_clock_out_o, tx_schedule_flag_out_o, tx_go_o;
    logic [2:0] linear_reg_current_limit_o, lim;
    logic [7:0] period, high;
    logic [15:0] rises, r0;
    logic [33:0] exp_q[$];
    int error_cnt = 0;
    int checks_done = 0;
    int seed = 27325;
    int n;
    always #4 clk_i = ~clk_i;
    supply_clock_trigger_ctrl DUT (.clk_i, .nrst_i, .status_i, .osc_source_select_i, .host_clock_rate_strap_i,
        .bus_load_strap_low_i, .tx_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o,
        .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i,
        .fixed_buck_run_o, .adj_buck_run_o, .linear_reg_run_o, .linear_reg_current_limit_o, .xtal_select_o,
        .high_slope_limit_o, .host_clock_out_o, .tx_schedule_flag_out_o, .tx_go_o);
    host_mcu_model host (.clk_i, .host_clock_i(host_clock_out_o), .period_o(period), .high_o(high), .rises_o(rises));
    task automatic test_done;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    task automatic chkw(input string nm, input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chkw
    task automatic chk1(input string nm, input logic e, input logic g);
        chkw(nm, {33'h0, e}, {33'h0, g});
    endtask : chk1
    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask : tick
    task automatic step;
        @(posedge clk_i);
        n++;
        if (n > 14000) begin
            error_cnt++;
            test_done();
        end
    endtask : step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w;
        awaddr_i <= a;
        wdata_i <= d;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        aw = 1'b0;
        w = 1'b0;
        n = 0;
        while (!(aw && w)) begin
            step();
            if (awready_o && !aw) begin
                aw = 1'b1;
                awvalid_i <= 1'b0;
            end
            if (wready_o && !w) begin
                w = 1'b1;
                wvalid_i <= 1'b0;
            end
        end
        do step(); while (!bvalid_o);
        chkw("bresp", {32'h0, (a == 4'h0 || a == 4'h4 || a == 4'h8) ? 2'h0 : 2'h2}, {32'h0, bresp_o});
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        exp_q.push_back(e);
        n = 0;
        do step(); while (!arready_o);
        arvalid_i <= 1'b0;
        do step(); while (!rvalid_o);
    endtask : rd
    always @(posedge clk_i) begin
        if (rvalid_o && rready_i) begin
            chkw("read", exp_q.pop_front(), {rresp_o, rdata_o});
        end
    end
    task automatic pulse(input tx_events_t e);
        tx_i <= e;
        @(posedge clk_i);
        tx_i <= '0;
        @(posedge clk_i);
    endtask : pulse
    task automatic wait_go;
        n = 0;
        while (!tx_go_o) step();
    endtask : wait_go
    task automatic clk_chk(input logic [7:0] p, input logic [7:0] h);
        tick(30);
        chkw("period", {26'h0, p}, {26'h0, period});
        chkw("high", {26'h0, h}, {26'h0, high});
    endtask : clk_chk
    initial begin
        nrst_i = 1'b0;
        status_i = 5'b10100;
        osc_source_select_i = 1'b0;
        host_clock_rate_strap_i = 1'b0;
        bus_load_strap_low_i = 1'b1;
        tx_i = '0;
        {awaddr_i, araddr_i, wstrb_i, wdata_i} = {8'h0, 4'hf, 32'h0};
        {awvalid_i, wvalid_i, arvalid_i, bready_i, rready_i} = 5'b00011;
        tick(10);
        nrst_i <= 1'b1;
        tick(8);
        chk1("fixed", 1'b1, fixed_buck_run_o);
        chk1("lin", 1'b1, linear_reg_run_o);
        chk1("xtal", 1'b1, xtal_select_o);
        chk1("slope", 1'b1, high_slope_limit_o);
        chkw("limit", 34'h4, {31'h0, linear_reg_current_limit_o});
        rd(4'h0, 34'he);
        rd(4'h8, 34'h4);
        rd(4'h4, 34'h5);
        rd(4'hc, {2'h2, 32'h0});
        wr(4'hc, 32'h1);
        rd(4'h0, 34'he);
        wr(4'h0, 32'hf);
        tick(3);
        chk1("adj", 1'b1, adj_buck_run_o);
        status_i.filtered_supply_ok <= 1'b0;
        tick(6);
        chk1("adj", 1'b0, adj_buck_run_o);
        chk1("lin", 1'b0, linear_reg_run_o);
        status_i.filtered_supply_ok <= 1'b1;
        wr(4'h0, 32'h8);
        tick(4);
        chk1("adj", 1'b0, adj_buck_run_o);
        chk1("lin", 1'b0, linear_reg_run_o);
        r0 = rises;
        tick(20);
        chkw("rises", {18'h0, r0}, {18'h0, rises});
        wr(4'h0, 32'he);
        lim = 3'($random(seed));
        wr(4'h8, {29'h0, lim});
        rd(4'h8, {31'h0, lim});
        chkw("limit", {31'h0, lim}, {31'h0, linear_reg_current_limit_o});
        osc_source_select_i <= 1'b1;
        bus_load_strap_low_i <= 1'b0;
        tick(5);
        chk1("xtal", 1'b0, xtal_select_o);
        chk1("slope", 1'b0, high_slope_limit_o);
        clk_chk(8'h8, 8'h1);
        status_i.normal_state <= 1'b1;
        clk_chk(8'h4, 8'h2);
        status_i.normal_state <= 1'b0;
        clk_chk(8'h4, 8'h2);
        status_i.normal_state <= 1'b1;
        host_clock_rate_strap_i <= 1'b1;
        clk_chk(8'h2, 8'h1);
        status_i <= 5'b10101;
        clk_chk(8'h8, 8'h1);
        pulse(5'b10000);
        pulse(5'b01000);
        wait_go();
        chk1("lead", 1'b1, n >= 12996 && n <= 13000);
        chk1("flag", 1'b1, tx_schedule_flag_out_o);
        pulse(5'b00010);
        chk1("flag", 1'b0, tx_schedule_flag_out_o);
        pulse(5'b01000);
        wait_go();
        chk1("prompt", 1'b1, n == 0 && tx_schedule_flag_out_o);
        pulse(5'b00001);
        chk1("flag", 1'b0, tx_schedule_flag_out_o);
        wr(4'h0, 32'h6);
        pulse(5'b01000);
        wait_go();
        chk1("flag", 1'b0, tx_schedule_flag_out_o);
        test_done();
    end
endmodule : supply_clock_trigger_ctrl_tb
